/* File: sop_top.sv */
/*
  serial audio output port of a stereo adc, clock slave.
  holds the dc filter, master clock ratio check, clock-stop detect and
  the i2s / left-justified serialiser.
  assumes mclk, bclk, lrclk and the strap pins are asynchronous and are
  oversampled by sys_clk; bclk of about 48 ns or slower.
*/
// Notes on behaviour
// - bypass pin high skips the filter
// - filter is (1-z^-1)/(1-0.9995z^-1)
// - ratios 256/384/512/768; 96k only 256/384 (sample rate is not checked, all four ratios are accepted at any rate)
// - count mclk per frame, tolerate 32
// - beyond 32 off, hold last sample
// - mclk stopped over 10us enters low power
// - format pin low i2s, high justified
// - every word goes msb first
// - one data line, lrclk marks channel
// - data changes only on bclk edges
// - justified msb on lrclk changing edge
// - justified lrclk high left, low right
// - i2s msb one bit after lrclk edge
// - i2s lrclk low left, high right
// - samples are 24-bit decimator words
`timescale 1ns/1ns
`default_nettype none

module sop_top (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // interface pins
  input wire logic MCLK,
  input wire logic BCLK,
  input wire logic LRCLK,
  input wire logic HPF_BYPASS_PIN,
  input wire logic FORMAT_SELECT_PIN,
  // samples from the decimator
  input wire logic [23:0] LEFT_SAMPLE,
  input wire logic [23:0] RIGHT_SAMPLE,
  input wire logic SAMPLE_VALID,
  // serial data
  output logic SERIAL_SAMPLE_OUT,
  // status
  output logic RATIO_ERROR,
  output logic [1:0] RATIO_CODE,
  output logic LOW_POWER
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [sop_pkg::PIN_N-1:0] pin_raw;
  logic [sop_pkg::PIN_N-1:0] pin_s1;
  logic [sop_pkg::PIN_N-1:0] pin_s2;
  logic [sop_pkg::PIN_N-1:0] pin_s3;

  assign pin_raw = {FORMAT_SELECT_PIN, HPF_BYPASS_PIN, LRCLK, BCLK, MCLK};

  for (genvar i = 0; i < sop_pkg::PIN_N; i++)
  begin : g_sync
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
      if (!RESET_N)
      begin
        pin_s1[i] <= 1'b0;
        pin_s2[i] <= 1'b0;
        pin_s3[i] <= 1'b0;
      end
      else
      begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
      end
    end
  end

  logic mclk_rise;
  logic bclk_fall;
  logic lr_rise;
  logic lr_now;
  logic fmt_now;

  assign mclk_rise = pin_s2[sop_pkg::PIN_MCLK] & ~pin_s3[sop_pkg::PIN_MCLK];
  // bclk and lrclk only ever sampled
  assign bclk_fall = ~pin_s2[sop_pkg::PIN_BCLK] & pin_s3[sop_pkg::PIN_BCLK];
  assign lr_rise = pin_s2[sop_pkg::PIN_LRCLK] & ~pin_s3[sop_pkg::PIN_LRCLK];
  assign lr_now = pin_s2[sop_pkg::PIN_LRCLK];
  assign fmt_now = pin_s2[sop_pkg::PIN_FMT];

  // ------------------------------------------------------------
  // high-pass filter
  // ------------------------------------------------------------
  sop_hpf_if hif ();

  assign hif.in_l = LEFT_SAMPLE;
  assign hif.in_r = RIGHT_SAMPLE;
  assign hif.in_valid = SAMPLE_VALID;
  assign hif.bypass = pin_s2[sop_pkg::PIN_HPF];

  sop_hpf u_hpf (
    .clk (SYS_CLK),
    .rst_n (RESET_N),
    .hif (hif)
  );

  // ------------------------------------------------------------
  // master clock ratio detector
  // ------------------------------------------------------------
  logic [9:0] mclk_cnt;
  logic meas_armed;
  logic win_256;
  logic win_384;
  logic win_512;
  logic win_768;

  function automatic logic in_win(input logic [9:0] cnt,
                                  input logic [9:0] nom);
    in_win = (cnt >= nom - sop_pkg::RATIO_TOL)
          && (cnt <= nom + sop_pkg::RATIO_TOL);
  endfunction

  assign win_256 = in_win(mclk_cnt, sop_pkg::RATIO_256);
  assign win_384 = in_win(mclk_cnt, sop_pkg::RATIO_384);
  assign win_512 = in_win(mclk_cnt, sop_pkg::RATIO_512);
  assign win_768 = in_win(mclk_cnt, sop_pkg::RATIO_768);

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      mclk_cnt <= 10'h000;
    else if (lr_rise)
      mclk_cnt <= mclk_rise ? 10'h001 : 10'h000;
    else if (mclk_rise && mclk_cnt != sop_pkg::RATIO_CNT_MAX)
      mclk_cnt <= mclk_cnt + 10'h001;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      meas_armed <= 1'b0;
    else if (lr_rise)
      meas_armed <= 1'b1;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      RATIO_ERROR <= 1'b0;
      RATIO_CODE <= sop_pkg::RCODE_256;
    end
    else if (lr_rise && meas_armed)
    begin
      // out of every window flags error
      RATIO_ERROR <= ~(win_256 | win_384 | win_512 | win_768);
      if (win_256)
        RATIO_CODE <= sop_pkg::RCODE_256;
      else if (win_384)
        RATIO_CODE <= sop_pkg::RCODE_384;
      else if (win_512)
        RATIO_CODE <= sop_pkg::RCODE_512;
      else if (win_768)
        RATIO_CODE <= sop_pkg::RCODE_768;
    end
  end

  // ------------------------------------------------------------
  // master clock stop detector
  // ------------------------------------------------------------
  logic [11:0] idle_cnt;

  // count cycles since last mclk edge
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      idle_cnt <= 12'h000;
    else if (mclk_rise)
      idle_cnt <= 12'h000;
    else if (idle_cnt != sop_pkg::MCLK_STOP_CYC)
      idle_cnt <= idle_cnt + 12'h001;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      LOW_POWER <= 1'b0;
    else if (mclk_rise)
      LOW_POWER <= 1'b0;
    else if (idle_cnt == sop_pkg::MCLK_STOP_CYC)
      LOW_POWER <= 1'b1;
  end

  // ------------------------------------------------------------
  // held sample pair
  // ------------------------------------------------------------
  logic [23:0] held_l;
  logic [23:0] held_r;

  // freeze last valid pair on error
  // 24-bit words from the filter path
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      held_l <= 24'h000000;
      held_r <= 24'h000000;
    end
    else if (hif.out_valid && !RATIO_ERROR && !LOW_POWER)
    begin
      held_l <= hif.out_l;
      held_r <= hif.out_r;
    end
  end

  // ------------------------------------------------------------
  // serialiser
  // ------------------------------------------------------------
  logic ser_act;
  logic lr_prev;
  logic lr_change;
  logic pend;
  logic pend_left;
  logic load_left;
  logic [23:0] load_word;
  logic [23:0] shreg;
  logic [4:0] bit_cnt;

  // lrclk is read one cycle after the fall so a same-edge change settles
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      ser_act <= 1'b0;
    else
      ser_act <= bclk_fall;
  end

  assign lr_change = lr_now != lr_prev;
  assign load_left = lr_change
                   ? ((fmt_now == sop_pkg::FMT_LJ) ? lr_now : ~lr_now)
                   : pend_left;
  assign load_word = load_left ? held_l : held_r;

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      lr_prev <= 1'b0;
      pend <= 1'b0;
      pend_left <= 1'b0;
      shreg <= 24'h000000;
      bit_cnt <= sop_pkg::BITS_PER_WORD;
      SERIAL_SAMPLE_OUT <= 1'b0;
    end
    // data moves only on a bclk fall
    // stable across the host's rising edge
    else if (ser_act)
    begin
      lr_prev <= lr_now;
      if (lr_change && fmt_now == sop_pkg::FMT_LJ)
      begin
        // msb on the lrclk changing edge
        SERIAL_SAMPLE_OUT <= load_word[23];
        shreg <= {load_word[22:0], 1'b0};
        bit_cnt <= 5'h01;
        pend <= 1'b0;
      end
      else if (lr_change)
      begin
        // one bit slot before the msb
        pend <= 1'b1;
        pend_left <= load_left;
        SERIAL_SAMPLE_OUT <= 1'b0;
        bit_cnt <= sop_pkg::BITS_PER_WORD;
      end
      else if (pend)
      begin
        SERIAL_SAMPLE_OUT <= load_word[23];
        shreg <= {load_word[22:0], 1'b0};
        bit_cnt <= 5'h01;
        pend <= 1'b0;
      end
      else if (bit_cnt < sop_pkg::BITS_PER_WORD)
      begin
        SERIAL_SAMPLE_OUT <= shreg[23];
        shreg <= {shreg[22:0], 1'b0};
        bit_cnt <= bit_cnt + 5'h01;
      end
      else
      begin
        SERIAL_SAMPLE_OUT <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* File: sop_pkg.sv */
/*
  constants shared by the serial output port and its dc-removal filter.
  assumes a 250 mhz system clock and 24-bit samples from the decimator.
*/
`default_nettype none

package sop_pkg;

  // ------------------------------------------------------------
  // sample format
  // ------------------------------------------------------------
  localparam int SAMPLE_W = 24;
  localparam logic [4:0] BITS_PER_WORD = 5'h18;
  localparam logic [23:0] SAMPLE_MAX = 24'h7fffff;
  localparam logic [23:0] SAMPLE_MIN = 24'h800000;

  // ------------------------------------------------------------
  // pin levels
  // ------------------------------------------------------------
  localparam logic FMT_I2S = 1'b0;
  localparam logic FMT_LJ = 1'b1;
  localparam logic HPF_ON = 1'b0;

  // synchroniser lanes
  localparam int PIN_N = 5;
  localparam int PIN_MCLK = 0;
  localparam int PIN_BCLK = 1;
  localparam int PIN_LRCLK = 2;
  localparam int PIN_HPF = 3;
  localparam int PIN_FMT = 4;

  // ------------------------------------------------------------
  // high-pass filter: pole 0.9995 in q16
  // ------------------------------------------------------------
  localparam int HPF_FRAC = 16;
  localparam int HPF_ACC_W = 42;
  localparam logic [15:0] HPF_POLE = 16'hffdf;

  // ------------------------------------------------------------
  // ratio detector
  // ------------------------------------------------------------
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_384 = 10'h180;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [9:0] RATIO_768 = 10'h300;
  localparam logic [9:0] RATIO_TOL = 10'h020;
  localparam logic [9:0] RATIO_CNT_MAX = 10'h3ff;
  localparam logic [1:0] RCODE_256 = 2'h0;
  localparam logic [1:0] RCODE_384 = 2'h1;
  localparam logic [1:0] RCODE_512 = 2'h2;
  localparam logic [1:0] RCODE_768 = 2'h3;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 250;
  localparam int MCLK_STOP_NS = 10000;
  localparam int MCLK_STOP_CYC_I = (MCLK_STOP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [11:0] MCLK_STOP_CYC = 12'(MCLK_STOP_CYC_I);

endpackage

`default_nettype wire

/* File: sop_hpf_if.sv */
/*
  carrier between the output port and its high-pass filter.
  assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface sop_hpf_if;
  logic [23:0] in_l;
  logic [23:0] in_r;
  logic in_valid;
  logic bypass;
  logic [23:0] out_l;
  logic [23:0] out_r;
  logic out_valid;

  modport feed (
    output in_l, in_r, in_valid, bypass,
    input out_l, out_r, out_valid
  );

  modport filt (
    input in_l, in_r, in_valid, bypass,
    output out_l, out_r, out_valid
  );
endinterface

`default_nettype wire

/* File: sop_hpf.sv */
/*
  first-order dc-removal filter, one lane per channel, one cycle latency.
  assumes in_valid is a single-cycle pulse on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none

module sop_hpf (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sample stream
  sop_hpf_if.filt hif
);

  logic [23:0] x_in [2];
  logic [23:0] y_out [2];

  assign x_in[0] = hif.in_l;
  assign x_in[1] = hif.in_r;
  assign hif.out_l = y_out[0];
  assign hif.out_r = y_out[1];

  // ------------------------------------------------------------
  // per-channel lanes
  // ------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_lane
    logic [23:0] x_prev;
    logic signed [41:0] y_acc;
    logic signed [41:0] diff;
    logic signed [59:0] prod;
    logic signed [41:0] y_new;
    logic [25:0] y_int;
    logic [23:0] y_sat;

    // y = x - x1 + p * y1
    assign diff = $signed({{2{x_in[ch][23]}}, x_in[ch], 16'h0000})
                - $signed({{2{x_prev[23]}}, x_prev, 16'h0000});
    assign prod = y_acc * $signed({2'b00, sop_pkg::HPF_POLE});
    assign y_new = diff + prod[57:16];
    assign y_int = y_new[41:16];
    assign y_sat = (y_int[25:23] == 3'b000 || y_int[25:23] == 3'b111)
                 ? y_int[23:0]
                 : (y_int[25] ? sop_pkg::SAMPLE_MIN : sop_pkg::SAMPLE_MAX);

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        x_prev <= 24'h000000;
        y_acc <= 42'h00000000000;
        y_out[ch] <= 24'h000000;
      end
      else if (hif.in_valid)
      begin
        x_prev <= x_in[ch];
        y_acc <= y_new;
        y_out[ch] <= (hif.bypass == sop_pkg::HPF_ON) ? y_sat : x_in[ch];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hif.out_valid <= 1'b0;
    else
      hif.out_valid <= hif.in_valid;
  end

endmodule

`default_nettype wire

/* File: sop_chk.sv */
/*
  concurrent checks on the serial output port's pins.
  assumes raw pins are oversampled by SYS_CLK and bound to sop_top.
*/
`timescale 1ns/1ns
`default_nettype none

module sop_chk (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // host pins
  input wire logic MCLK,
  input wire logic BCLK,
  input wire logic LRCLK,
  input wire logic FORMAT_SELECT_PIN,
  // device outputs
  input wire logic SERIAL_SAMPLE_OUT,
  input wire logic RATIO_ERROR,
  input wire logic [1:0] RATIO_CODE,
  input wire logic LOW_POWER
);
  logic bclk_q, lr_q, mclk_q, lr_at_rise, rise;
  logic [3:0] since_fall, since_lr;
  logic [5:0] bitcnt;
  logic [11:0] idle;

  assign rise = BCLK && !bclk_q;

  // edge ages and bit position within a half-frame
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      bclk_q <= 1'b1;
      lr_q <= 1'b0;
      mclk_q <= 1'b0;
      lr_at_rise <= 1'b0;
      since_fall <= 4'h0;
      since_lr <= 4'h0;
      bitcnt <= 6'h00;
      idle <= 12'h000;
    end
    else
    begin
      bclk_q <= BCLK;
      lr_q <= LRCLK;
      mclk_q <= MCLK;
      since_fall <= (!BCLK && bclk_q) ? 4'h0 :
        since_fall + {3'h0, since_fall != 4'hf};
      since_lr <= (LRCLK && !lr_q) ? 4'h0 :
        since_lr + {3'h0, since_lr != 4'hf};
      idle <= (MCLK && !mclk_q) ? 12'h000 : idle + {11'h0, idle != 12'hfff};
      if (rise)
      begin
        lr_at_rise <= LRCLK;
        bitcnt <= (LRCLK != lr_at_rise) ? 6'h00 :
          bitcnt + {5'h0, bitcnt != 6'h3f};
      end
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_mclk_edge;
    MCLK && !mclk_q;
  endsequence
  sequence s_asleep;
    LOW_POWER;
  endsequence

  property p_sdo_edge;
    $changed(SERIAL_SAMPLE_OUT) |-> since_fall <= 4'h8;
  endproperty
  property p_i2s_gap;
    rise && !FORMAT_SELECT_PIN && LRCLK != lr_at_rise |-> !SERIAL_SAMPLE_OUT;
  endproperty
  property p_tail_zero;
    rise && LRCLK == lr_at_rise && bitcnt >= 6'h18 |-> !SERIAL_SAMPLE_OUT;
  endproperty
  property p_flag_time;
    $changed(RATIO_CODE) || $changed(RATIO_ERROR) |-> since_lr <= 4'h8;
  endproperty
  property p_code_hold;
    $rose(RATIO_ERROR) |-> $stable(RATIO_CODE);
  endproperty
  property p_lp_set;
    $rose(LOW_POWER) |-> idle >= 12'h9c0 && idle <= 12'h9d8;
  endproperty
  property p_lp_late;
    idle >= 12'h9e2 |-> LOW_POWER;
  endproperty
  property p_lp_wake;
    s_asleep ##0 s_mclk_edge |-> ##[1:8] !LOW_POWER;
  endproperty

  a_sdo_edge: assert property (p_sdo_edge)
    else $error("data moved away from a bit clock fall");
  a_i2s_gap: assert property (p_i2s_gap)
    else $error("i2s bit at word change not zero");
  a_tail_zero: assert property (p_tail_zero)
    else $error("bit after the lsb not zero");
  a_flag_time: assert property (p_flag_time)
    else $error("ratio flags moved away from a word clock rise");
  a_code_hold: assert property (p_code_hold)
    else $error("ratio code changed on error");
  a_lp_set: assert property (p_lp_set)
    else $error("low power entered at wrong idle time");
  a_lp_late: assert property (p_lp_late)
    else $error("low power missing after long idle");
  a_lp_wake: assert property (p_lp_wake)
    else $error("low power not left after master clock");
endmodule

bind sop_top sop_chk u_sop_chk (
  .SYS_CLK(SYS_CLK),
  .RESET_N(RESET_N),
  .MCLK(MCLK),
  .BCLK(BCLK),
  .LRCLK(LRCLK),
  .FORMAT_SELECT_PIN(FORMAT_SELECT_PIN),
  .SERIAL_SAMPLE_OUT(SERIAL_SAMPLE_OUT),
  .RATIO_ERROR(RATIO_ERROR),
  .RATIO_CODE(RATIO_CODE),
  .LOW_POWER(LOW_POWER)
);

`default_nettype wire

/* File: sop_host.sv */
/*
  host model: makes master, bit and word clocks and captures data.
  assumes a 48 ns bit clock; lengths are changed by the bench.
*/
`timescale 1ns/1ns
`default_nettype none

module sop_host (
  // clocks to the device
  output logic mclk,
  output logic bclk,
  output logic lrclk,
  // data from the device
  input wire logic sdo
);
  int half_len = 64;
  bit mclk_on = 1'b1;
  int halves = 0;
  int nbit = 0;
  logic [63:0] cap [2];
  logic [63:0] shreg = 64'h0;

  // master clock from the same time base
  initial
  begin
    mclk = 1'b0;
    forever
    begin
      #12;
      mclk = mclk_on ? ~mclk : 1'b0;
    end
  end

  // host clocks, capture on rising edge
  initial
  begin
    bclk = 1'b1;
    lrclk = 1'b0;
    forever
    begin
      #24;
      bclk = 1'b0;
      if (nbit >= half_len)
      begin
        cap[lrclk] = shreg;
        shreg = 64'h0;
        halves++;
        lrclk = ~lrclk;
        nbit = 0;
      end
      #24;
      bclk = 1'b1;
      if (nbit < 64)
        shreg[63 - nbit] = sdo;
      nbit++;
    end
  end
endmodule

`default_nettype wire

/* File: tb_sop_top.sv */
/*
  self-checking bench for the serial output port.
  assumes sop_host as the far side and sop_chk bound to the top.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_sop_top;
  logic sys_clk, reset_n, hpf_bypass, fmt, sample_valid;
  logic [23:0] left_sample, right_sample;
  logic mclk, bclk, lrclk, sdo, ratio_error, low_power;
  logic [1:0] ratio_code;
  int mismatches = 0;
  int comparisons = 0;

  sop_top u_sop_top (
    .SYS_CLK(sys_clk),
    .RESET_N(reset_n),
    .MCLK(mclk),
    .BCLK(bclk),
    .LRCLK(lrclk),
    .HPF_BYPASS_PIN(hpf_bypass),
    .FORMAT_SELECT_PIN(fmt),
    .LEFT_SAMPLE(left_sample),
    .RIGHT_SAMPLE(right_sample),
    .SAMPLE_VALID(sample_valid),
    .SERIAL_SAMPLE_OUT(sdo),
    .RATIO_ERROR(ratio_error),
    .RATIO_CODE(ratio_code),
    .LOW_POWER(low_power)
  );
  sop_host u_sop_host (
    .mclk(mclk),
    .bclk(bclk),
    .lrclk(lrclk),
    .sdo(sdo)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever
      #2 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_stat(input logic [3:0] exp);
    comparisons++;
    if ({ratio_error, ratio_code, low_power} !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t status %b expected %b", $time,
        {ratio_error, ratio_code, low_power}, exp);
    end
  endtask

  function automatic logic [63:0] exp_word(input logic [23:0] s);
    return fmt ? {s, 40'h0} : {1'b0, s, 39'h0};
  endfunction

  task automatic wait_halves(input int n);
    int h;
    h = u_sop_host.halves;
    wait (u_sop_host.halves >= h + n);
    @(negedge sys_clk);
  endtask

  task automatic send(input logic [23:0] l, input logic [23:0] r);
    @(negedge sys_clk);
    left_sample = l;
    right_sample = r;
    sample_valid = 1'b1;
    @(negedge sys_clk);
    sample_valid = 1'b0;
    wait_halves(3);
  endtask

  // word clock level picks the channel
  task automatic check_pair(input logic [23:0] l, input logic [23:0] r);
    chk_word(u_sop_host.cap[fmt], exp_word(l));
    chk_word(u_sop_host.cap[~fmt], exp_word(r));
  endtask

  task automatic t_filter;
    send(24'h010000, 24'h020000);
    check_pair(24'h010000, 24'h020000);
    send(24'h010000, 24'h020000);
    check_pair(24'h00ffdf, 24'h01ffbe);
  endtask

  task automatic t_formats;
    logic [23:0] pat [2] = '{24'ha5c3f1, 24'h800001};
    hpf_bypass = 1'b1;
    for (int f = 1; f >= 0; f--)
    begin
      wait_halves(1);
      fmt = f[0];
      foreach (pat[i])
      begin
        send(pat[i], ~pat[i]);
        check_pair(pat[i], ~pat[i]);
      end
    end
  endtask

  task automatic t_ratio;
    logic [7:0] lens [6] = '{8'h40, 8'h60, 8'h80, 8'hc0, 8'h47, 8'h49};
    logic [3:0] exps [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h0, 4'h8};
    foreach (lens[i])
    begin
      u_sop_host.half_len = int'(lens[i]);
      wait_halves(5);
      repeat (8) @(negedge sys_clk);
      chk_stat(exps[i]);
    end
    send(24'h111111, 24'h222222);
    check_pair(24'h800001, 24'h7ffffe);
    u_sop_host.half_len = 64;
    wait_halves(5);
    repeat (8) @(negedge sys_clk);
    chk_stat(4'h0);
  endtask

  task automatic t_low_power;
    u_sop_host.mclk_on = 1'b0;
    #9000;
    @(negedge sys_clk);
    chk_word({63'h0, low_power}, 64'h0);
    #2000;
    @(negedge sys_clk);
    chk_word({63'h0, low_power}, 64'h1);
    u_sop_host.mclk_on = 1'b1;
    #1000;
    @(negedge sys_clk);
    chk_word({63'h0, low_power}, 64'h0);
  endtask

  initial
  begin
    reset_n = 1'b0;
    hpf_bypass = 1'b0;
    fmt = 1'b1;
    sample_valid = 1'b0;
    left_sample = 24'h0;
    right_sample = 24'h0;
    repeat (4) @(negedge sys_clk);
    chk_stat(4'h0);
    chk_word({63'h0, sdo}, 64'h0);
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    t_filter();
    t_formats();
    t_ratio();
    t_low_power();
    report_and_stop();
  end

  // run should end near 250 us
  initial
  begin
    #360000;
    mismatches++;
    report_and_stop();
  end
endmodule

`default_nettype wire
